// >>> include/gpm_pkg.sv
// What this block does
// - Pins reset undriven; debug pins alt, enabled, pulled-up
// - Every reset restores both pin groups' defaults
// - Input direction: data bit captures the pad
// - Output direction: data bit drives the pad
// - Address bits 9:2 mask the data register
// - Data write changes only address-selected bits
// - Data read returns zero for unselected bits
// - One interrupt output for any enabled pending pin
// - Rising, falling, both edges, or high/low level
// - Edge interrupt stays latched until software clears
// - Mask gates forwarding; masked status shows forwarded
// - Raw status shows triggers regardless of mask
// - Writing one clears latched interrupt; zero ignored
// - Unmasked trigger on port B pin 4 also pulses ADC trigger
// - Alt select hands pad to peripheral function
// - Protected alt select needs unlock and commit
// - Only five debug pins are commit-protected
// - Per-pin pad drive, drain, pulls, slew, enable
// - Eight peripheral and four cell identity words
// - Each port is an independent copy
package gpm_pkg;
   // ==========================================
   // Register offsets
   localparam logic [11:0] OFF_DIR = 12'h400;
   localparam logic [11:0] OFF_IS = 12'h404;
   localparam logic [11:0] OFF_IBE = 12'h408;
   localparam logic [11:0] OFF_IEV = 12'h40C;
   localparam logic [11:0] OFF_IM = 12'h410;
   localparam logic [11:0] OFF_RIS = 12'h414;
   localparam logic [11:0] OFF_MIS = 12'h418;
   localparam logic [11:0] OFF_ICR = 12'h41C;
   localparam logic [11:0] OFF_AFSEL = 12'h420;
   localparam logic [11:0] OFF_DRV2 = 12'h500;
   localparam logic [11:0] OFF_DRV4 = 12'h504;
   localparam logic [11:0] OFF_DRV8 = 12'h508;
   localparam logic [11:0] OFF_ODR = 12'h50C;
   localparam logic [11:0] OFF_PUR = 12'h510;
   localparam logic [11:0] OFF_PDR = 12'h514;
   localparam logic [11:0] OFF_SLR = 12'h518;
   localparam logic [11:0] OFF_DEN = 12'h51C;
   localparam logic [11:0] OFF_LOCK = 12'h520;
   localparam logic [11:0] OFF_CR = 12'h524;
   localparam logic [11:0] OFF_PID = 12'hFD0;
   localparam logic [11:0] OFF_CID = 12'hFF0;
   localparam logic [11:0] DATA_SPAN = 12'h400;
   // ==========================================
   // Reset values and constants
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_DRV2 = 8'hFF;
   localparam logic [7:0] RST_CR = 8'hFF;
   localparam int PORT_B = 1;
   localparam int PORT_C = 2;
   localparam int ADC_PIN = 4;
   localparam logic [7:0] DBG_MASK_B = 8'h80;
   localparam logic [7:0] DBG_MASK_C = 8'h0F;
   // Arbitrary unlock key
   localparam logic [31:0] UNLOCK_KEY = 32'h5A5A_C3C3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Identity words, values arbitrary
   localparam logic [7:0] PID_WORDS [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                            8'h11, 8'h22, 8'h33, 8'h44};
   localparam logic [7:0] CID_WORDS [4] = '{8'h55, 8'h66, 8'h77, 8'h88};
   // ==========================================
   // Pad configuration carrier
   typedef struct packed {
      logic [7:0] drv2;
      logic [7:0] drv4;
      logic [7:0] drv8;
      logic [7:0] open_drain;
      logic [7:0] pull_up;
      logic [7:0] pull_down;
      logic [7:0] slew;
      logic [7:0] dig_en;
   } gpm_pad_cfg_t;

   function automatic logic [7:0] gpm_debug_mask(input int port);
      return (port == PORT_B) ? DBG_MASK_B : (port == PORT_C) ? DBG_MASK_C : RST_ZERO;
   endfunction
endpackage

// >>> rtl/gpm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module gpm_sync #(
   parameter int WIDTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         q <= '0;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/gpm_port.sv
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module gpm_port #(
   parameter int PORT_IDX = 0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe,
   output gpm_pkg::gpm_pad_cfg_t pad_cfg,
   input wire logic [7:0] alt_out,
   input wire logic [7:0] alt_oe,
   output logic [7:0] alt_in,
   output logic irq,
   output logic adc_trigger
);
   import gpm_pkg::*;

   localparam logic [7:0] DBG = gpm_debug_mask(PORT_IDX);
   localparam bit HAS_ADC = (PORT_IDX == PORT_B);

   if (PORT_IDX < 0 || PORT_IDX > 7) begin : g_bad_port
      $error("PORT_IDX must be 0 to 7");
   end

   // ==========================================
   // Bus slave state
   logic [11:0] aw_addr_r, ar_addr_r;
   logic [31:0] w_data_r;
   logic w_lane_r, aw_got_r, w_got_r, rd_pend_r;
   logic [7:0] data_r, dir_r, is_r, ibe_r, iev_r, im_r, ris_r, afsel_r, cr_r;
   logic locked_r;
   logic [7:0] sync_q, prev_r;
   gpm_pad_cfg_t cfg_r;

   wire do_wr = aw_got_r && w_got_r && !bvalid;
   wire wr_data = aw_addr_r < DATA_SPAN;
   wire [7:0] wr_mask = aw_addr_r[9:2];
   wire [7:0] wv = w_data_r[7:0];
   wire wl = do_wr && w_lane_r;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction

   function automatic logic [7:0] upd(input logic [7:0] old, input logic en,
                                      input logic [7:0] val);
      return en ? val : old;
   endfunction

   wire wr_dir = wl && hit(aw_addr_r, OFF_DIR);
   wire wr_is = wl && hit(aw_addr_r, OFF_IS);
   wire wr_ibe = wl && hit(aw_addr_r, OFF_IBE);
   wire wr_iev = wl && hit(aw_addr_r, OFF_IEV);
   wire wr_im = wl && hit(aw_addr_r, OFF_IM);
   wire wr_icr = wl && hit(aw_addr_r, OFF_ICR);
   wire wr_afsel = wl && hit(aw_addr_r, OFF_AFSEL);
   wire wr_cr = wl && hit(aw_addr_r, OFF_CR) && !locked_r;
   wire wr_lock = do_wr && hit(aw_addr_r, OFF_LOCK);
   wire wr_dat = wl && wr_data;
   // Mask as it stands after this edge, so irq never lags a mask write
   wire [7:0] im_nxt = upd(im_r, wr_im, wv);

   function automatic logic known(input logic [11:0] a);
      return (a < DATA_SPAN) || (a >= OFF_DIR && a <= OFF_AFSEL && a[1:0] == 2'h0)
         || (a >= OFF_DRV2 && a <= OFF_CR && a[1:0] == 2'h0)
         || (a >= OFF_PID && a[1:0] == 2'h0);
   endfunction

   // ==========================================
   // Write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         aw_addr_r <= 12'h000;
         w_data_r <= 32'h0000_0000;
         w_lane_r <= 1'b0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_addr_r <= awaddr;
            aw_got_r <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data_r <= wdata;
            w_lane_r <= wstrb[0];
            w_got_r <= 1'b1;
            wready <= 1'b0;
         end
         if (do_wr) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid <= 1'b1;
            bresp <= known(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ==========================================
   // Read channel
   logic [7:0] rd_val;
   wire [11:0] ra = ar_addr_r;
   wire [7:0] rd_mask = ra[9:2];
   wire [7:0] mis = ris_r & im_r;

   always_comb begin
      rd_val = RST_ZERO;
      if (ra < DATA_SPAN) begin
         rd_val = data_r & rd_mask;
      end else if (ra >= OFF_PID && ra < OFF_CID) begin
         rd_val = PID_WORDS[ra[4:2]];
      end else if (ra >= OFF_CID) begin
         rd_val = CID_WORDS[ra[3:2]];
      end else begin
         case (ra)
            OFF_DIR: rd_val = dir_r;
            OFF_IS: rd_val = is_r;
            OFF_IBE: rd_val = ibe_r;
            OFF_IEV: rd_val = iev_r;
            OFF_IM: rd_val = im_r;
            OFF_RIS: rd_val = ris_r;
            OFF_MIS: rd_val = mis;
            OFF_AFSEL: rd_val = afsel_r;
            OFF_DRV2: rd_val = cfg_r.drv2;
            OFF_DRV4: rd_val = cfg_r.drv4;
            OFF_DRV8: rd_val = cfg_r.drv8;
            OFF_ODR: rd_val = cfg_r.open_drain;
            OFF_PUR: rd_val = cfg_r.pull_up;
            OFF_PDR: rd_val = cfg_r.pull_down;
            OFF_SLR: rd_val = cfg_r.slew;
            OFF_DEN: rd_val = cfg_r.dig_en;
            OFF_LOCK: rd_val = {7'h00, locked_r};
            OFF_CR: rd_val = cr_r;
            default: rd_val = RST_ZERO;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rd_pend_r <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
         ar_addr_r <= 12'h000;
      end else if (ce) begin
         if (arvalid && arready) begin
            ar_addr_r <= araddr;
            arready <= 1'b0;
            rd_pend_r <= 1'b1;
         end
         if (rd_pend_r) begin
            rdata <= {24'h00_0000, rd_val};
            rresp <= known(ra) ? RESP_OKAY : RESP_SLVERR;
            rvalid <= 1'b1;
            rd_pend_r <= 1'b0;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // ==========================================
   // Configuration registers
   wire [7:0] af_ok = ~DBG | (cr_r & {8{!locked_r}});

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dir_r <= RST_ZERO;
         is_r <= RST_ZERO;
         ibe_r <= RST_ZERO;
         iev_r <= RST_ZERO;
         im_r <= RST_ZERO;
         afsel_r <= DBG;
         cr_r <= RST_CR & ~DBG;
         locked_r <= 1'b1;
         cfg_r <= '{drv2: RST_DRV2, dig_en: DBG, pull_up: DBG, default: RST_ZERO};
      end else if (ce) begin
         dir_r <= upd(dir_r, wr_dir, wv);
         is_r <= upd(is_r, wr_is, wv);
         ibe_r <= upd(ibe_r, wr_ibe, wv);
         iev_r <= upd(iev_r, wr_iev, wv);
         im_r <= im_nxt;
         afsel_r <= upd(afsel_r, wr_afsel, (wv & af_ok) | (afsel_r & ~af_ok));
         cr_r <= upd(cr_r, wr_cr, (wv & DBG) | (cr_r & ~DBG));
         if (wr_lock) begin
            locked_r <= (w_data_r != UNLOCK_KEY);
         end
         if (wl) begin
            cfg_r.drv2 <= upd(cfg_r.drv2, hit(aw_addr_r, OFF_DRV2), wv);
            cfg_r.drv4 <= upd(cfg_r.drv4, hit(aw_addr_r, OFF_DRV4), wv);
            cfg_r.drv8 <= upd(cfg_r.drv8, hit(aw_addr_r, OFF_DRV8), wv);
            cfg_r.open_drain <= upd(cfg_r.open_drain, hit(aw_addr_r, OFF_ODR), wv);
            cfg_r.pull_up <= upd(cfg_r.pull_up, hit(aw_addr_r, OFF_PUR), wv);
            cfg_r.pull_down <= upd(cfg_r.pull_down, hit(aw_addr_r, OFF_PDR), wv);
            cfg_r.slew <= upd(cfg_r.slew, hit(aw_addr_r, OFF_SLR), wv);
            cfg_r.dig_en <= upd(cfg_r.dig_en, hit(aw_addr_r, OFF_DEN), wv);
         end
      end
   end

   // ==========================================
   // Pad input path and data register
   gpm_sync #(.WIDTH(8)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .d(pad_in),
      .q(sync_q)
   );

   wire [7:0] in_v = sync_q & cfg_r.dig_en;
   wire [7:0] wr_bits = {8{wr_dat}} & wr_mask;
   wire [7:0] data_nxt = (data_r & ~wr_bits & dir_r) | (wv & wr_bits & dir_r)
      | (in_v & ~dir_r);

   // ==========================================
   // Interrupt detection
   wire [7:0] rise = in_v & ~prev_r;
   wire [7:0] fall = ~in_v & prev_r;
   wire [7:0] edge_hit = ~is_r & (((rise | fall) & ibe_r)
      | (((rise & iev_r) | (fall & ~iev_r)) & ~ibe_r));
   wire [7:0] lvl_hit = is_r & ((in_v & iev_r) | (~in_v & ~iev_r));
   wire [7:0] trig = edge_hit | lvl_hit;
   wire [7:0] clr_v = {8{wr_icr}} & wv;
   wire [7:0] ris_nxt = (ris_r & ~clr_v) | trig;
   wire [7:0] mis_nxt = ris_nxt & im_nxt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_r <= RST_ZERO;
         prev_r <= RST_ZERO;
         ris_r <= RST_ZERO;
         irq <= 1'b0;
         adc_trigger <= 1'b0;
         pad_out <= RST_ZERO;
         pad_oe <= RST_ZERO;
         pad_cfg <= '0;
         alt_in <= RST_ZERO;
      end else if (ce) begin
         data_r <= data_nxt;
         prev_r <= in_v;
         ris_r <= ris_nxt;
         irq <= |mis_nxt;
         adc_trigger <= HAS_ADC && im_nxt[ADC_PIN] && trig[ADC_PIN];
         pad_out <= (afsel_r & alt_out) | (~afsel_r & data_nxt & ~cfg_r.open_drain);
         pad_oe <= (afsel_r & alt_oe)
            | (~afsel_r & dir_r & (~cfg_r.open_drain | ~data_nxt));
         pad_cfg <= cfg_r;
         alt_in <= in_v;
      end
   end

   // ==========================================
   // Assertions
   sequence s_data_write;
      ce && wr_dat;
   endsequence

   sequence s_icr_write;
      ce && wr_icr;
   endsequence

   a_irq_any_pending: assert property (@(posedge aclk) disable iff (!aresetn)
      ce ##1 1'b1 |-> irq == |(ris_r & im_r))
      else $error("irq does not match pending masked status");

   a_edge_latched: assert property (@(posedge aclk) disable iff (!aresetn)
      ce |=> ((($past(ris_r) & ~$past(clr_v)) & ~ris_r) == 8'h00))
      else $error("latched interrupt dropped without clear");

   a_clear_wins_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      s_icr_write |=> ((ris_r & $past(clr_v) & ~$past(trig)) == 8'h00))
      else $error("interrupt clear had no effect");

   a_data_wr_mask: assert property (@(posedge aclk) disable iff (!aresetn)
      s_data_write |=> (((data_r ^ $past(data_r)) & ~$past(wr_mask)
      & $past(dir_r)) == 8'h00))
      else $error("unselected data bit changed on write");

   a_data_rd_mask: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(rvalid) && (ar_addr_r < DATA_SPAN) |-> ((rdata[7:0] & ~ar_addr_r[9:2])
      == 8'h00) && rdata[31:8] == 24'h00_0000)
      else $error("masked data read returned nonzero bits");

   a_input_capture: assert property (@(posedge aclk) disable iff (!aresetn)
      ce |=> (((data_r ^ $past(in_v)) & ~$past(dir_r)) == 8'h00))
      else $error("input pin not captured in data register");

   a_gpio_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      ce |=> (((pad_oe ^ $past(dir_r)) & ~$past(afsel_r)
      & ~$past(cfg_r.open_drain)) == 8'h00))
      else $error("output enable does not follow direction");

   a_alt_handover: assert property (@(posedge aclk) disable iff (!aresetn)
      ce |=> (((pad_oe ^ $past(alt_oe)) & $past(afsel_r)) == 8'h00))
      else $error("alternate pin not under peripheral control");

   a_afsel_protect: assert property (@(posedge aclk) disable iff (!aresetn)
      ce |=> (((afsel_r ^ $past(afsel_r)) & DBG & ~$past(cr_r & {8{!locked_r}}))
      == 8'h00))
      else $error("protected alternate select changed without commit");

   a_adc_pulse_cause: assert property (@(posedge aclk) disable iff (!aresetn)
      adc_trigger |-> HAS_ADC && ris_r[ADC_PIN] && irq)
      else $error("ADC trigger without pending pin interrupt");
endmodule
`default_nettype wire

// >>> verif/gpm_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpm_pad_model (
   input wire logic aclk,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire gpm_pkg::gpm_pad_cfg_t pad_cfg,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] pad_in
);
   import gpm_pkg::*;
   // ==========================================
   // Pad wire resolution
   // Undriven and unpulled pins wander every cycle
   logic [7:0] float_r = 8'h55;
   always @(posedge aclk) begin
      float_r <= ~float_r;
   end
   // External source holds its level until the bench changes it
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad_oe[i]) begin
            pad_in[i] = pad_out[i];
         end else if (ext_en[i]) begin
            pad_in[i] = ext_val[i];
         end else if (pad_cfg.pull_up[i]) begin
            pad_in[i] = 1'b1;
         end else if (pad_cfg.pull_down[i]) begin
            pad_in[i] = 1'b0;
         end else begin
            pad_in[i] = float_r[i];
         end
      end
   end
endmodule
`default_nettype wire

// >>> verif/gpio_port_with_masked_access_test.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_with_masked_access_test;
   import gpm_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [7:0] alt_out = 8'h00, alt_oe = 8'h00, ext_en = 8'hF0, ext_val = 8'h20;
   logic awready, wready, bvalid, arready, rvalid, irq, adc_trigger;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, d;
   logic [7:0] pad_in, pad_out, pad_oe, alt_in;
   gpm_pad_cfg_t pad_cfg;
   int fail_count = 0;
   int n_checks = 0;
   int adc_cnt = 0;

   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      if (adc_trigger === 1'b1) adc_cnt <= adc_cnt + 1;
   end

   gpm_port #(.PORT_IDX(PORT_B)) dut (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr,
      .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
      .araddr, .rvalid, .rready, .rdata, .rresp, .pad_in, .pad_out, .pad_oe, .pad_cfg,
      .alt_out, .alt_oe, .alt_in, .irq, .adc_trigger);
   gpm_pad_model pads (.aclk, .pad_out, .pad_oe, .pad_cfg, .ext_en, .ext_val, .pad_in);

   // ==========================================
   // Verdict and comparison
   task automatic report_and_stop();
      if (fail_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bound(input int n);
      if (n >= 200) begin
         fail_count++;
         $display("ERROR %0t: bus wait ran out", $time);
         report_and_stop();
      end
   endtask
   // ==========================================
   // Bus master
   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
      logic ad, wd, ga, gw;
      int n;
      ad = 1'b0;
      wd = 1'b0;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd) && n < 200) begin
         @(negedge aclk);
         ga = !ad && awready;
         gw = !wd && wready;
         @(posedge aclk);
         if (ga) awvalid <= 1'b0;
         if (gw) wvalid <= 1'b0;
         ad = ad | ga;
         wd = wd | gw;
         n++;
      end
      bound(n);
      n = 0;
      do begin
         @(negedge aclk);
         n++;
      end while (bvalid !== 1'b1 && n < 200);
      bound(n);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         n++;
      end while (arready !== 1'b1 && n < 200);
      bound(n);
      @(posedge aclk);
      arvalid <= 1'b0;
      n = 0;
      do begin
         @(negedge aclk);
         n++;
      end while (rvalid !== 1'b1 && n < 200);
      bound(n);
      v = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask
   task automatic wok(input logic [11:0] a, input logic [31:0] v);
      wr(a, v, rsp);
      chk(rsp, RESP_OKAY);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      rd(a, d, rsp);
      chk(d, exp);
      chk(rsp, RESP_OKAY);
   endtask
   task automatic defaults();
      rc(OFF_AFSEL, DBG_MASK_B);
      rc(OFF_DEN, DBG_MASK_B);
      rc(OFF_PUR, DBG_MASK_B);
      rc(OFF_PDR, RST_ZERO);
      rc(OFF_DIR, RST_ZERO);
      rc(OFF_DRV2, RST_DRV2);
      rc(OFF_CR, RST_CR & ~DBG_MASK_B);
      rc(OFF_LOCK, 32'h1);
      chk(pad_oe, RST_ZERO);
      chk(pad_cfg.pull_up, DBG_MASK_B);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      defaults();
      wr(12'h600, 32'h1, rsp);
      chk(rsp, RESP_SLVERR);
      rd(12'h600, d, rsp);
      chk(rsp, RESP_SLVERR);
      chk(d, 32'h0);
      // Upper four words sit first in the window
      for (int i = 0; i < 8; i++) rc(OFF_PID + 12'(4 * i), PID_WORDS[(i + 4) % 8]);
      for (int i = 0; i < 4; i++) rc(OFF_CID + 12'(4 * i), CID_WORDS[i]);
      // Masked data access, low nibble driven
      wok(OFF_DEN, 32'hFF);
      wok(OFF_DIR, 32'h0F);
      wok(12'h3FC, 32'h05);
      repeat (2) @(posedge aclk);
      chk({pad_oe[3:0], pad_out[3:0]}, 8'hF5);
      wok(12'h098, 32'hEB);
      repeat (2) @(posedge aclk);
      chk(pad_out[3:0], 4'h3);
      rc(12'h3FC, 32'h23);
      rc(12'h0C4, 32'h21);
      // Trigger setup while masked
      wok(OFF_IS, 32'h80);
      wok(OFF_IBE, 32'h40);
      wok(OFF_IEV, 32'h90);
      wok(OFF_ICR, 32'hFF);
      rc(OFF_RIS, 32'h0);
      wok(OFF_IM, 32'hF0);
      ext_val <= 8'h30;
      repeat (6) @(posedge aclk);
      chk(adc_cnt, 1);
      chk(irq, 1'b1);
      ext_val <= 8'h10;
      repeat (6) @(posedge aclk);
      ext_val <= 8'h50;
      repeat (6) @(posedge aclk);
      ext_val <= 8'hD0;
      repeat (6) @(posedge aclk);
      rc(OFF_RIS, 32'hF0);
      wok(OFF_IM, 32'h10);
      rc(OFF_MIS, 32'h10);
      rc(OFF_RIS, 32'hF0);
      ext_val <= 8'hC0;
      repeat (6) @(posedge aclk);
      rc(OFF_RIS, 32'hF0);
      chk(adc_cnt, 1);
      wok(OFF_ICR, 32'h30);
      rc(OFF_RIS, 32'hC0);
      rc(OFF_MIS, 32'h0);
      chk(irq, 1'b0);
      ext_val <= 8'h40;
      repeat (6) @(posedge aclk);
      wok(OFF_ICR, 32'hC0);
      ext_val <= 8'h00;
      repeat (6) @(posedge aclk);
      rc(OFF_RIS, 32'h40);
      wok(OFF_IS, 32'hA0);
      repeat (4) @(posedge aclk);
      rc(OFF_RIS, 32'h60);
      // Clock enable low hides a rising trigger pin until released
      ce <= 1'b0;
      ext_val <= 8'h10;
      repeat (6) @(posedge aclk);
      chk(adc_cnt, 1);
      ce <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(adc_cnt, 2);
      chk(irq, 1'b1);
      // Commit protection and hand-over
      wok(OFF_AFSEL, 32'h01);
      rc(OFF_AFSEL, 32'h81);
      repeat (2) @(posedge aclk);
      chk({pad_out[0], pad_oe[0]}, 2'b00);
      alt_out <= 8'h01;
      alt_oe <= 8'h01;
      repeat (3) @(posedge aclk);
      chk({pad_out[0], pad_oe[0]}, 2'b11);
      wok(OFF_LOCK, UNLOCK_KEY);
      rc(OFF_LOCK, 32'h0);
      wok(OFF_CR, 32'hFF);
      rc(OFF_CR, 32'hFF);
      wok(OFF_AFSEL, 32'h00);
      rc(OFF_AFSEL, 32'h00);
      wok(OFF_SLR, 32'h3C);
      rc(OFF_SLR, 32'h3C);
      repeat (2) @(posedge aclk);
      chk(pad_cfg.slew, 8'h3C);
      // Open drain on pin 1: high releases, low sinks
      wok(OFF_ODR, 32'h02);
      repeat (2) @(posedge aclk);
      chk({pad_out[1], pad_oe[1]}, 2'b00);
      wok(12'h008, 32'h00);
      repeat (2) @(posedge aclk);
      chk({pad_out[1], pad_oe[1]}, 2'b01);
      // Second reset restores defaults
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      defaults();
      report_and_stop();
   end
endmodule
`default_nettype wire
